// *** rtl/port_regs_map.svh ***
`ifndef PORT_REGS_MAP_SVH
`define PORT_REGS_MAP_SVH

// address width and register byte offsets
`define AXI_ADDR_W       12
`define DEV_WORD_OFF     12'h0C8
`define IRQ_STATUS_OFF   12'h0E0
`define IRQ_MASK_OFF     12'h0E4

// control half, bits 15:0
`define F_REP_EN_MSB     3
`define F_REP_EN_LSB     0
`define F_RELAX_ORD      4
`define F_MPS_MSB        7
`define F_MPS_LSB        5
`define F_EXT_TAG        8
`define F_PHANTOM        9
`define F_AUX_PM_EN      10
`define F_NO_SNOOP       11
`define F_MRRS_MSB       14
`define F_MRRS_LSB       12
`define F_CTRL_RSVD      15

// status half, bits 31:16
`define F_ERR_MSB        19
`define F_ERR_LSB        16
`define F_AUX_DET        20
`define F_TRANS_PEND     21
`define F_STAT_RSVD_MSB  31
`define F_STAT_RSVD_LSB  22

// interrupt event layout
`define IRQ_W            5
`define IRQ_AUX_BIT      4

// reset values
`define REP_EN_RST       4'h0
`define MPS_RST          3'h0
`define AUX_PM_EN_RST    1'b0
`define AUX_DET_RST      1'b1
`define IMASK_RST        5'h00

`endif

// *** rtl/port_regs_pkg.sv ***
package port_regs_pkg;

  typedef enum logic [1:0] {
    RESP_OKAY   = 2'h0,
    RESP_SLVERR = 2'h2
  } resp_t;

endpackage

// *** rtl/sticky_flags.sv ***
`timescale 1ns/10ps
module sticky_flags #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic             soft_clr,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  output logic      [WIDTH-1:0] flags
);

  // set beats both write-one clear and soft clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= '0;
    end else if (ce) begin
      if (soft_clr) begin
        flags <= set;
      end else begin
        flags <= (flags & ~clr) | set;
      end
    end
  end

endmodule

// *** rtl/port_device_control_status_regs.sv ***
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "port_regs_map.svh"
// Functional notes
// - the relaxed-ordering enable bit always reads zero and ignores writes.
// - control bits 7:5 hold a writable payload limit that resets to 000b.
// - a written payload code above the supported maximum stores that maximum.
// - extended-tag and phantom-function enables always read zero and reset to zero.
// - control bit 10 is a writable sticky aux power enable that resets to zero.
// - the no-snoop enable bit always reads zero and resets to zero.
// - the read-request size field in bits 14:12 is hardwired to 000b.
// - status bits 16 to 19 set on the four error classes, clear on write one, reset zero.
// - each error class is logged whether or not its reporting enable is set.
// - status bit 20 shows detected aux power and resets to one.
// - the transactions-pending bit 21 is hardwired to zero.
module port_device_control_status_regs #(
  parameter logic [2:0] MPS_MAX = 3'h1
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   ce,
  input  wire logic                   hot_rst,
  input  wire logic [3:0]             err_evt,
  input  wire logic                   aux_power_pin,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [`AXI_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]             awprot,
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  input  wire logic                   arvalid,
  output logic                        arready,
  input  wire logic [`AXI_ADDR_W-1:0] araddr,
  input  wire logic [2:0]             arprot,
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic [2:0]                  max_payload,
  output logic                        aux_power_en,
  output logic                        irq
);

  logic                       aw_full;
  logic [`AXI_ADDR_W-1:0]     aw_addr;
  logic                       w_full;
  logic [31:0]                w_data;
  logic [3:0]                 w_strb;
  logic                       wr_go;
  logic                       wr_dev;
  logic                       wr_istat;
  logic                       wr_imask;
  logic                       wr_mapped;
  logic                       rd_go;
  port_regs_pkg::resp_t       bresp_q;
  port_regs_pkg::resp_t       rresp_q;

  logic [3:0]                 rep_en;
  logic [2:0]                 mps;
  logic [2:0]                 next_mps;
  logic                       aux_pm_en;
  logic [3:0]                 err_flags;
  logic [3:0]                 err_clr;
  logic                       aux_s1;
  logic                       aux_s2;
  logic                       aux_s3;
  logic                       aux_det;
  logic                       aux_evt;
  logic [`IRQ_W-1:0]          irq_set;
  logic [`IRQ_W-1:0]          irq_clr;
  logic [`IRQ_W-1:0]          istat;
  logic [`IRQ_W-1:0]          imask;
  logic [31:0]                dev_word;
  logic [31:0]                next_rdata;
  port_regs_pkg::resp_t       next_rresp;

  assign awready = ce & ~aw_full;
  assign wready  = ce & ~w_full;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_full <= 1'b1;
        aw_addr <= awaddr;
      end else if (wr_go) begin
        aw_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (ce) begin
      if (wvalid && wready) begin
        w_full <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end else if (wr_go) begin
        w_full <= 1'b0;
      end
    end
  end

  // write commits once both halves are held and no response waits
  assign wr_go     = ce & aw_full & w_full & ~bvalid;
  assign wr_dev    = wr_go & ({aw_addr[`AXI_ADDR_W-1:2], 2'h0} == `DEV_WORD_OFF);
  assign wr_istat  = wr_go & ({aw_addr[`AXI_ADDR_W-1:2], 2'h0} == `IRQ_STATUS_OFF);
  assign wr_imask  = wr_go & ({aw_addr[`AXI_ADDR_W-1:2], 2'h0} == `IRQ_MASK_OFF);
  assign wr_mapped = wr_dev | wr_istat | wr_imask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid  <= 1'b0;
      bresp_q <= port_regs_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid  <= 1'b1;
        bresp_q <= wr_mapped ? port_regs_pkg::RESP_OKAY : port_regs_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  assign bresp = bresp_q;

  // clamp an oversize payload code to the supported maximum
  always_comb begin
    next_mps = w_data[`F_MPS_MSB:`F_MPS_LSB];
    if (next_mps > MPS_MAX) begin
      next_mps = MPS_MAX;
    end
  end

  // hot reset restores non-sticky fields and blocks writes that cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rep_en <= `REP_EN_RST;
      mps    <= `MPS_RST;
    end else if (ce) begin
      if (hot_rst) begin
        rep_en <= `REP_EN_RST;
        mps    <= `MPS_RST;
      end else if (wr_dev && w_strb[0]) begin
        rep_en <= w_data[`F_REP_EN_MSB:`F_REP_EN_LSB];
        mps    <= next_mps;
      end
    end
  end

  // aux enable survives hot reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_pm_en <= `AUX_PM_EN_RST;
    end else if (ce && !hot_rst && wr_dev && w_strb[1]) begin
      aux_pm_en <= w_data[`F_AUX_PM_EN];
    end
  end

  assign max_payload  = mps;
  assign aux_power_en = aux_pm_en;

  assign err_clr = (wr_dev && w_strb[2]) ? w_data[`F_ERR_MSB:`F_ERR_LSB] : 4'h0;

  // flags log every class, reporting enables do not gate them
  sticky_flags #(
    .WIDTH (4)
  ) u_err_flags (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .soft_clr (hot_rst),
    .set      (err_evt),
    .clr      (err_clr),
    .flags    (err_flags)
  );

  // aux power pin synchroniser, change taken when stages 2 and 3 agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_s1 <= `AUX_DET_RST;
      aux_s2 <= `AUX_DET_RST;
      aux_s3 <= `AUX_DET_RST;
    end else if (ce) begin
      aux_s1 <= aux_power_pin;
      aux_s2 <= aux_s1;
      aux_s3 <= aux_s2;
    end
  end

  assign aux_evt = (aux_s2 == aux_s3) & (aux_s3 != aux_det);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_det <= `AUX_DET_RST;
    end else if (ce && aux_s2 == aux_s3) begin
      aux_det <= aux_s3;
    end
  end

  assign irq_set = {aux_evt, err_evt};
  assign irq_clr = (wr_istat && w_strb[0]) ? w_data[`IRQ_W-1:0] : '0;

  sticky_flags #(
    .WIDTH (`IRQ_W)
  ) u_irq_flags (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .soft_clr (1'b0),
    .set      (irq_set),
    .clr      (irq_clr),
    .flags    (istat)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      imask <= `IMASK_RST;
    end else if (ce && wr_imask && w_strb[0]) begin
      imask <= w_data[`IRQ_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(istat & imask);
    end
  end

  // fixed-zero fields are never stored, so writes cannot reach them
  always_comb begin
    dev_word                                 = 32'h0000_0000;
    dev_word[`F_REP_EN_MSB:`F_REP_EN_LSB]    = rep_en;
    dev_word[`F_MPS_MSB:`F_MPS_LSB]          = mps;
    dev_word[`F_AUX_PM_EN]                   = aux_pm_en;
    dev_word[`F_ERR_MSB:`F_ERR_LSB]          = err_flags;
    dev_word[`F_AUX_DET]                     = aux_det;
  end

  assign arready = ce & ~rvalid;
  assign rd_go   = arvalid & arready;

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = port_regs_pkg::RESP_OKAY;
    if ({araddr[`AXI_ADDR_W-1:2], 2'h0} == `DEV_WORD_OFF) begin
      next_rdata = dev_word;
    end else if ({araddr[`AXI_ADDR_W-1:2], 2'h0} == `IRQ_STATUS_OFF) begin
      next_rdata[`IRQ_W-1:0] = istat;
    end else if ({araddr[`AXI_ADDR_W-1:2], 2'h0} == `IRQ_MASK_OFF) begin
      next_rdata[`IRQ_W-1:0] = imask;
    end else begin
      next_rresp = port_regs_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp_q <= port_regs_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        rvalid  <= 1'b1;
        rdata   <= next_rdata;
        rresp_q <= next_rresp;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  assign rresp = rresp_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic                       dev_rd;
  assign dev_rd = rd_go & ({araddr[`AXI_ADDR_W-1:2], 2'h0} == `DEV_WORD_OFF);

  property p_relax_ord_zero;
    dev_rd |=> (rvalid && rdata[`F_RELAX_ORD] == 1'b0);
  endproperty
  a_relax_ord_zero: assert property (p_relax_ord_zero) else $error("relaxed order on");
  property p_mps_store;
    (wr_dev && w_strb[0] && !hot_rst && w_data[`F_MPS_MSB:`F_MPS_LSB] <= MPS_MAX)
      |=> (mps == $past(w_data[`F_MPS_MSB:`F_MPS_LSB]));
  endproperty
  a_mps_store: assert property (p_mps_store) else $error("payload not stored");
  property p_mps_clamp;
    (wr_dev && w_strb[0] && !hot_rst && w_data[`F_MPS_MSB:`F_MPS_LSB] > MPS_MAX)
      |=> (mps == MPS_MAX);
  endproperty
  a_mps_clamp: assert property (p_mps_clamp) else $error("payload not clamped");
  property p_tag_phantom_zero;
    dev_rd |=> (rdata[`F_PHANTOM:`F_EXT_TAG] == 2'h0);
  endproperty
  a_tag_phantom_zero: assert property (p_tag_phantom_zero) else $error("tag bits set");
  property p_aux_en_sticky;
    (ce && hot_rst) |=> (aux_pm_en == $past(aux_pm_en));
  endproperty
  a_aux_en_sticky: assert property (p_aux_en_sticky) else $error("aux enable lost");
  property p_no_snoop_zero;
    dev_rd |=> (rdata[`F_NO_SNOOP] == 1'b0);
  endproperty
  a_no_snoop_zero: assert property (p_no_snoop_zero) else $error("no snoop set");
  property p_mrrs_zero;
    dev_rd |=> (rdata[`F_MRRS_MSB:`F_MRRS_LSB] == 3'h0);
  endproperty
  a_mrrs_zero: assert property (p_mrrs_zero) else $error("read size set");
  property p_err_set;
    (ce && err_evt != 4'h0) |=> ((err_flags & $past(err_evt)) == $past(err_evt));
  endproperty
  a_err_set: assert property (p_err_set) else $error("error not logged");
  property p_err_hold;
    (err_flags[1] && !err_clr[1] && !(ce && hot_rst)) |=> err_flags[1];
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag lost");
  property p_err_unreported;
    (ce && err_evt[2] && !rep_en[2]) |=> err_flags[2];
  endproperty
  a_err_unreported: assert property (p_err_unreported) else $error("fatal not logged");
  property p_aux_det_reset;
    $rose(aresetn) |-> aux_det;
  endproperty
  a_aux_det_reset: assert property (p_aux_det_reset) else $error("aux not one");
  property p_aux_det_follow;
    (ce && aux_s2 == aux_s3) |=> (aux_det == $past(aux_s3));
  endproperty
  a_aux_det_follow: assert property (p_aux_det_follow) else $error("aux not tracked");
  property p_pend_zero;
    dev_rd |=> (rdata[`F_TRANS_PEND] == 1'b0);
  endproperty
  a_pend_zero: assert property (p_pend_zero) else $error("pending set");
  property p_rsvd_zero;
    dev_rd |=> (rdata[`F_STAT_RSVD_MSB:`F_STAT_RSVD_LSB] == 10'h000 && !rdata[`F_CTRL_RSVD]);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved set");
  property p_irq_level;
    ce |=> (irq == $past(|(istat & imask)));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt output wrong");

  c_err_logged: cover property (ce && err_evt[0] ##1 err_flags[0]);
  c_clamp:      cover property (wr_dev && w_strb[0] && w_data[`F_MPS_MSB:`F_MPS_LSB] > MPS_MAX);
  c_irq_rise:   cover property ($rose(irq));
  c_dev_read:   cover property (dev_rd);

endmodule

// *** bench/port_device_control_status_regs_tb.sv ***
`timescale 1ns/10ps
`include "port_regs_map.svh"
module port_device_control_status_regs_tb;
  localparam logic [2:0]  MPS_MAX = 3'h2;
  localparam logic [31:0] AUX     = 32'h0010_0000;
  localparam logic [31:0] AUXEN   = 32'h0000_0400;
  localparam logic [1:0]  OK      = port_regs_pkg::RESP_OKAY;
  localparam logic [1:0]  SLV     = port_regs_pkg::RESP_SLVERR;
  localparam logic [11:0] DEV     = `DEV_WORD_OFF;
  localparam logic [11:0] ISTAT   = `IRQ_STATUS_OFF;
  localparam logic [11:0] IMASK   = `IRQ_MASK_OFF;

  logic        aclk, aresetn, ce, hot_rst, aux_power_pin, irq, aux_power_en;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [3:0]  err_evt, wstrb;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [2:0]  max_payload;
  int          fail_count;
  int          comparisons;

  port_device_control_status_regs #(.MPS_MAX(MPS_MAX)) DUT (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .hot_rst(hot_rst), .err_evt(err_evt),
    .aux_power_pin(aux_power_pin), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .max_payload(max_payload),
    .aux_power_en(aux_power_en), .irq(irq)
  );

  initial aclk = 1'b0;
  always #50 aclk = ~aclk;

  task automatic finish_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // write: both address and data offered at once, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    bit         aw_hs;
    bit         w_hs;
    bit         b_hs;
    bit         b_ok;
    logic [1:0] got_r;
    int         n;
    aw_hs = 0;
    w_hs = 0;
    b_hs = 0;
    b_ok = 0;
    got_r = 2'h0;
    n = 0;
    // one idle edge keeps a new request off the edge that closed the last one
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok && n < 50) begin
      // handshakes sampled mid-cycle, where they stand up to the next edge
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      got_r = bresp;
      @(posedge aclk);
      n++;
      if (aw_hs) begin
        awvalid <= 1'b0;
      end
      if (w_hs) begin
        wvalid <= 1'b0;
      end
      if (b_hs) begin
        b_ok = 1;
        bready <= 1'b0;
        chk($sformatf("bresp@%h", a), 32'(er), 32'(got_r));
      end
    end
    if (!b_ok) begin
      fail_count++;
      finish_test();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit          ar_hs;
    bit          r_hs;
    bit          r_ok;
    logic [31:0] got_d;
    logic [1:0]  got_r;
    int          n;
    ar_hs = 0;
    r_hs = 0;
    r_ok = 0;
    got_d = 32'h0000_0000;
    got_r = 2'h0;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok && n < 50) begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      r_hs = rvalid;
      got_d = rdata;
      got_r = rresp;
      @(posedge aclk);
      n++;
      if (ar_hs) begin
        arvalid <= 1'b0;
      end
      if (r_hs) begin
        r_ok = 1;
        rready <= 1'b0;
        chk($sformatf("rdata@%h", a), ed, got_d);
        chk($sformatf("rresp@%h", a), 32'(er), 32'(got_r));
      end
    end
    if (!r_ok) begin
      fail_count++;
      finish_test();
    end
  endtask

  task automatic pulse_err(input logic [3:0] v);
    err_evt <= v;
    @(posedge aclk);
    err_evt <= 4'h0;
    @(posedge aclk);
  endtask

  initial begin
    logic [2:0]  exp_mps;
    logic [31:0] ebit;
    fail_count = 0;
    comparisons = 0;
    aresetn = 1'b0;
    ce = 1'b1;
    hot_rst = 1'b0;
    err_evt = 4'h0;
    aux_power_pin = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(DEV, AUX, OK);
    chk("max_payload", 32'h0, 32'(max_payload));
    chk("aux_power_en", 32'h0, 32'(aux_power_en));
    rd(IMASK, 32'h0, OK);
    rd(ISTAT, 32'h0, OK);
    // every payload code, fixed-zero control bits written as ones
    for (int c = 0; c < 8; c++) begin
      exp_mps = (3'(c) > MPS_MAX) ? MPS_MAX : 3'(c);
      wr(DEV, 32'h0000_FF1F | (32'(c) << 5), 4'h3, OK);
      rd(DEV, AUX | AUXEN | 32'h0000_000F | (32'(exp_mps) << 5), OK);
      chk("max_payload", 32'(exp_mps), 32'(max_payload));
    end
    chk("aux_power_en", 32'h1, 32'(aux_power_en));
    hot_rst <= 1'b1;
    @(posedge aclk);
    hot_rst <= 1'b0;
    @(posedge aclk);
    rd(DEV, AUX | AUXEN, OK);
    wr(DEV, 32'hFFF0_0000, 4'hC, OK);
    rd(DEV, AUX | AUXEN, OK);
    // each error class with its reporting enable off
    wr(IMASK, 32'h0000_000F, 4'hF, OK);
    for (int i = 0; i < 4; i++) begin
      ebit = 32'h1 << (16 + i);
      pulse_err(4'h1 << i);
      rd(DEV, AUX | AUXEN | ebit, OK);
      chk("irq", 32'h1, 32'(irq));
      wr(DEV, ebit | AUXEN, 4'hB, OK);
      rd(DEV, AUX | AUXEN | ebit, OK);
      wr(DEV, ebit | AUXEN, 4'h4, OK);
      rd(DEV, AUX | AUXEN, OK);
      rd(ISTAT, 32'h1 << i, OK);
      wr(ISTAT, 32'h1 << i, 4'hF, OK);
      @(posedge aclk);
      chk("irq", 32'h0, 32'(irq));
    end
    wr(IMASK, 32'h0, 4'hF, OK);
    pulse_err(4'h8);
    rd(ISTAT, 32'h8, OK);
    chk("irq", 32'h0, 32'(irq));
    wr(ISTAT, 32'h8, 4'hF, OK);
    wr(DEV, 32'h0008_0400, 4'h4, OK);
    // aux power removed and restored
    aux_power_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(DEV, AUXEN, OK);
    rd(ISTAT, 32'h10, OK);
    wr(IMASK, 32'h10, 4'hF, OK);
    @(posedge aclk);
    chk("irq", 32'h1, 32'(irq));
    wr(ISTAT, 32'h10, 4'hF, OK);
    @(posedge aclk);
    chk("irq", 32'h0, 32'(irq));
    aux_power_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(DEV, AUX | AUXEN, OK);
    wr(ISTAT, 32'h10, 4'hF, OK);
    wr(IMASK, 32'h0, 4'hF, OK);
    // events are ignored while the clock enable is low; hot reset clears logged errors
    ce <= 1'b0;
    pulse_err(4'h2);
    ce <= 1'b1;
    rd(DEV, AUX | AUXEN, OK);
    pulse_err(4'h2);
    rd(DEV, AUX | AUXEN | 32'h0002_0000, OK);
    hot_rst <= 1'b1;
    @(posedge aclk);
    hot_rst <= 1'b0;
    rd(DEV, AUX | AUXEN, OK);
    wr(ISTAT, 32'h2, 4'hF, OK);
    wr(12'h100, 32'hFFFF_FFFF, 4'hF, SLV);
    rd(12'h100, 32'h0, SLV);
    rd(DEV, AUX | AUXEN, OK);
    finish_test();
  end
endmodule
